// ---- tb/ofs_load_model.sv ----
// load model: external controller watching the four output terminals
`timescale 1ns/1ns

module ofs_load_model (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [3:0] term, // terminal levels {c2,c1,fast,oc}
  output logic [15:0] pulse_cnt // rising edges seen on the fast terminal
);
  // ------------
  // pulse count
  // ------------
  logic fast_q; // last fast level, for edge detect

  // counts like a pulse input would; ideal load, so no debounce
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fast_q <= 1'b0;
      pulse_cnt <= 16'h0000;
    end else begin
      fast_q <= term[1];
      if (term[1] && !fast_q) begin
        pulse_cnt <= pulse_cnt + 16'h0001;
      end
    end
  end
endmodule // ofs_load_model

// ---- tb/ofs_top_tb.sv ----
// self-checking bench for the output function selector
`timescale 1ns/1ns
`include "ofs_defs.svh"

module ofs_top_tb;
  import ofs_pkg::*;
  // ------------
  // signals
  // ------------
  localparam int HOLD = 20; // short index hold keeps the run brief
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd; // apb data, rd is the last read
  logic [41:0] st; // status inputs, bit 41 is the pulse train
  logic [3:0] outs; // {c2,c1,fast,oc}
  logic [15:0] pulse_cnt; // edges counted by the load
  ofs_code_t code_q [4]; // codes programmed per terminal
  logic mode_q, pen_q; // fast digital mode, program enable
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  ofs_top #(.ADDR_W(8), .INDEX_HOLD_CYC(HOLD)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drv_running(st[0]), .rate_nonzero(st[1]), .dir_reverse(st[2]), .jog_active(st[3]),
    .drv_fault(st[4]), .level_detect_one(st[5]), .level_detect_two(st[6]),
    .rate_reached(st[7]), .out_rate_zero(st[8]), .ref_rate_zero(st[9]),
    .at_upper_limit(st[10]), .at_lower_limit(st[11]), .main_pwr_ok(st[12]),
    .ctrl_pwr_ok(st[13]), .protect_active(st[14]), .drive_ready(st[15]),
    .pre_excite(st[16]), .overload_alarm(st[17]), .underload_alarm(st[18]),
    .seq_stage_done(st[19]), .seq_cycle_done(st[20]), .virt_serial_bit(st[21]),
    .virt_fieldbus_bit(st[22]), .virt_ethernet_bit(st[23]), .virt_industrial_bit(st[24]),
    .dc_bus_ok(st[25]), .enc_index(st[26]), .pulse_superpose(st[27]),
    .safe_torque_off(st[28]), .position_done(st[29]), .spindle_zero_done(st[30]),
    .spindle_div_done(st[31]), .rate_limited(st[32]), .mode_switch_done(st[33]),
    .logic_pgm_oc_one(st[34]), .logic_pgm_oc_two(st[35]), .logic_pgm_fast_out(st[36]),
    .logic_pgm_contact_one(st[37]), .logic_pgm_contact_two(st[38]),
    .logic_pgm_contact_three(st[39]), .logic_pgm_contact_four(st[40]),
    .fast_pulse_in(st[41]), .oc_out(outs[0]), .fast_pulse_output(outs[1]),
    .contact_one_out(outs[2]), .contact_two_out(outs[3]));

  ofs_load_model load_u (.mclk(mclk), .arst_n(arst_n), .term(outs), .pulse_cnt(pulse_cnt));

  // ------------
  // helpers
  // ------------
  // status bits that must all be high for a code to turn on
  function automatic logic [41:0] req_of(input logic [5:0] c);
    req_of = '0;
    if (c >= 6'h05 && c <= 6'h08) req_of[c - 6'h01] = 1'b1;
    if (c == 6'h0a || c == 6'h0b) req_of[c] = 1'b1;
    if (c >= 6'h0d && c <= 6'h11) req_of[c + 6'h03] = 1'b1;
    if (c >= 6'h17 && c <= 6'h19) req_of[c - 6'h02] = 1'b1;
    if (c == 6'h1a || (c >= 6'h1c && c <= 6'h21)) req_of[c - 6'h01] = 1'b1;
    if (c >= 6'h29 && c <= 6'h2f) req_of[c - 6'h07] = 1'b1;
    case (c)
      6'h01, 6'h02: req_of = 42'h3;
      6'h03: req_of = 42'h7;
      6'h04: req_of = 42'ha;
      6'h09: req_of = 42'h300;
      6'h0c: req_of = 42'hb000;
      6'h22: req_of = 42'h100_0000;
      6'h24: req_of = 42'h2_0000_0000;
      default: ;
    endcase
  endfunction

  // level a terminal should show; unlisted codes stay off
  function automatic logic exp_lvl(input logic [5:0] c, input logic [41:0] s);
    exp_lvl = (req_of(c) != '0) && ((s & req_of(c)) == req_of(c));
    if (c == 6'h02) exp_lvl = exp_lvl && !s[2];
    if (c == 6'h0c) exp_lvl = exp_lvl && !s[14];
    if (c >= 6'h29 && c <= 6'h2f) exp_lvl = exp_lvl && pen_q;
  endfunction

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex,
                        input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    cmp(nm, ex, rd);
    cmp({nm, " err"}, {31'h0, ee}, {31'h0, er});
  endtask

  // program the four codes, fast mode and program enable
  task automatic prog();
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(i * 4), {26'h0, code_q[i]});
    apb(1'b1, `OFS_OFF_CTRL, {30'h0, pen_q, mode_q});
  endtask

  // hold a status pattern long enough to pass the pipeline, then check
  task automatic drive(input logic [41:0] s);
    logic [3:0] ex;
    @(posedge mclk);
    st <= s;
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < 4; i++) ex[i] = exp_lvl(code_q[i], s);
    if (!mode_q) ex[1] = s[41];
    cmp("terminals", {28'h0, ex}, {28'h0, outs});
  endtask

  task automatic conclude();
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------
  // clock, timeout, sequence
  // ------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // a hung handshake ends here; the whole run needs about 18600 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  initial begin : main
    logic [41:0] base;
    int n;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    st = '0;
    repeat (16) @(posedge mclk);
    cmp("reset terminals", 32'h0, {28'h0, outs});
    arst_n <= 1'b1;
    rd_chk("sel oc", `OFS_OFF_SEL_OC, {26'h0, `OFS_RST_SEL_OC}, 1'b0);
    rd_chk("sel fast", `OFS_OFF_SEL_FAST, {26'h0, `OFS_RST_SEL_FAST}, 1'b0);
    rd_chk("sel c1", `OFS_OFF_SEL_C1, {26'h0, `OFS_RST_SEL_C1}, 1'b0);
    rd_chk("sel c2", `OFS_OFF_SEL_C2, {26'h0, `OFS_RST_SEL_C2}, 1'b0);
    rd_chk("ctrl", `OFS_OFF_CTRL, 32'h0, 1'b0);
    apb(1'b1, `OFS_OFF_STATUS, 32'hffff_ffff);
    rd_chk("status", `OFS_OFF_STATUS, 32'h0, 1'b0);
    rd_chk("unmapped", 8'h18, 32'h0, 1'b1);
    apb(1'b1, `OFS_OFF_SEL_OC, 32'hffff_ffff);
    rd_chk("sel width", `OFS_OFF_SEL_OC, 32'h3f, 1'b0);
    // every code, both program enables, one status bit flipped at a time
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 64; c++) begin
        code_q[0] = 6'(c);
        code_q[1] = 6'(c);
        code_q[2] = 6'(c);
        code_q[3] = 6'(63 - c);
        mode_q = 1'b1;
        pen_q = p[0];
        prog();
        base = req_of(6'(c));
        drive('0);
        drive(base);
        for (int i = 0; i < 42; i++) if (i != 26) drive(base ^ (42'h1 << i));
      end
    end
    // pulse mode: fast terminal copies the train and the load counts it
    mode_q = 1'b0;
    prog();
    // the last scenario left the train bit high, so the mode switch itself
    // makes an edge; let it settle before the load count is taken
    drive('0);
    n = int'(pulse_cnt);
    for (int i = 0; i < 6; i++) drive({i[0], 41'h0});
    repeat (2) @(posedge mclk);
    cmp("pulse count", 32'(n + 3), {16'h0, pulse_cnt});
    // index pulse held for the shortened hold time
    code_q[0] = 6'h1b;
    prog();
    @(posedge mclk);
    st <= 42'h400_0000;
    @(posedge mclk);
    st <= '0;
    n = 0;
    repeat (HOLD + 8) begin
      @(posedge mclk);
      #1;
      if (outs[0] === 1'b1) n++;
    end
    cmp("index hold", 32'(HOLD), 32'(n));
    conclude();
  end
endmodule // ofs_top_tb

// ---- verilog/ofs_defs.svh ----
// constants of the output function selector: codes, offsets, reset values, timing
`ifndef OFS_DEFS_SVH
`define OFS_DEFS_SVH

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define OFS_CODE_W 6
`define OFS_FN_NONE 6'h00
`define OFS_FN_RUN 6'h01
`define OFS_FN_FWD 6'h02
`define OFS_FN_REV 6'h03
`define OFS_FN_JOG 6'h04
`define OFS_FN_FAULT 6'h05
`define OFS_FN_LVL_ONE 6'h06
`define OFS_FN_LVL_TWO 6'h07
`define OFS_FN_RATE_HIT 6'h08
`define OFS_FN_ZERO_SPD 6'h09
`define OFS_FN_UPPER 6'h0a
`define OFS_FN_LOWER 6'h0b
`define OFS_FN_READY 6'h0c
`define OFS_FN_PREEXC 6'h0d
`define OFS_FN_OVERLOAD 6'h0e
`define OFS_FN_UNDERLOAD 6'h0f
`define OFS_FN_STAGE 6'h10
`define OFS_FN_CYCLE 6'h11
`define OFS_FN_VIRT_SER 6'h17
`define OFS_FN_VIRT_FLD 6'h18
`define OFS_FN_VIRT_ETH 6'h19
`define OFS_FN_DC_BUS 6'h1a
`define OFS_FN_INDEX 6'h1b
`define OFS_FN_SUPERPOSE 6'h1c
`define OFS_FN_SAFE_OFF 6'h1d
`define OFS_FN_POS_DONE 6'h1e
`define OFS_FN_ZERO_DONE 6'h1f
`define OFS_FN_DIV_DONE 6'h20
`define OFS_FN_LIMITED 6'h21
`define OFS_FN_VIRT_IND 6'h22
`define OFS_FN_RSV_A 6'h23
`define OFS_FN_SWITCHED 6'h24
`define OFS_FN_RSV_LO 6'h25
`define OFS_FN_RSV_HI 6'h28
`define OFS_FN_PGM_LO 6'h29
`define OFS_FN_PGM_HI 6'h2f
`define OFS_FN_TOP_RSV 6'h30
`define OFS_PGM_BITS 7

// ----------------------------------------------------------------
// register map (byte addresses) and reset values
// ----------------------------------------------------------------
`define OFS_OFF_SEL_OC 8'h00
`define OFS_OFF_SEL_FAST 8'h04
`define OFS_OFF_SEL_C1 8'h08
`define OFS_OFF_SEL_C2 8'h0c
`define OFS_OFF_CTRL 8'h10
`define OFS_OFF_STATUS 8'h14
`define OFS_RST_SEL_OC 6'h00
`define OFS_RST_SEL_FAST 6'h00
`define OFS_RST_SEL_C1 6'h01
`define OFS_RST_SEL_C2 6'h05
`define OFS_CTRL_MODE_BIT 0
`define OFS_CTRL_PGM_BIT 1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OFS_CLK_KHZ 250000
`define OFS_INDEX_HOLD_MS 10

`endif

// ---- verilog/ofs_pkg.sv ----
// types of the output function selector
package ofs_pkg;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [5:0] ofs_code_t; // one function code
  typedef enum logic [1:0] {
    OFS_FAST_PULSE = 2'b01, // fast output carries the pulse train
    OFS_FAST_DIGITAL = 2'b10 // fast output acts as a digital output
  } ofs_fast_mode_e;
endpackage

// ---- verilog/ofs_top.sv ----
// output function selector: four programmable outputs behind an apb slave
//
// Function
// - four outputs; fast one pulse or digital
// - same code usable on several outputs
// - code 0 holds output inactive
// - code 1: running with nonzero rate
// - codes 2/3: forward / reverse output
// - code 4: output during jog
// - code 5: drive fault
// - code 9: actual and reference rate zero
// - codes 10/11: upper / lower limit reached
// - code 12: powers up, no protection, ready
// - code 13: during pre-excitation
// - codes 14/15: overload / underload pre-alarm
// - codes 16/17: sequencer stage / cycle done
// - codes 23-25,34: virtual link bits
// - code 26: dc bus above undervoltage
// - code 27: index pulse held 10 ms
// - code 28: pulse superposition active
// - code 29: safe torque off fault
// - codes 30-32: positioning, zeroing, division done
// - code 33: rate held by limit
// - code 36: speed/position switch-over done
// - codes 41-47: logic program bits when enabled
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "ofs_defs.svh"

module ofs_top
  import ofs_pkg::*;
#(
  parameter int ADDR_W = 8, // apb address width
  parameter int INDEX_HOLD_CYC = `OFS_INDEX_HOLD_MS * `OFS_CLK_KHZ // index hold cycles
) (
  input wire logic mclk, // system clock, 250 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic drv_running, // drive in run state
  input wire logic rate_nonzero, // output rate is nonzero
  input wire logic dir_reverse, // running in reverse
  input wire logic jog_active, // jog operation
  input wire logic drv_fault, // drive fault present
  input wire logic level_detect_one, // first level-detect flag
  input wire logic level_detect_two, // second level-detect flag
  input wire logic rate_reached, // rate-reached flag
  input wire logic out_rate_zero, // actual rate is zero
  input wire logic ref_rate_zero, // reference rate is zero
  input wire logic at_upper_limit, // rate at upper limit
  input wire logic at_lower_limit, // rate at lower limit
  input wire logic main_pwr_ok, // main power established
  input wire logic ctrl_pwr_ok, // control power established
  input wire logic protect_active, // a protection function acts
  input wire logic drive_ready, // drive ready to run
  input wire logic pre_excite, // pre-excitation in progress
  input wire logic overload_alarm, // overload pre-alarm elapsed
  input wire logic underload_alarm, // underload pre-alarm elapsed
  input wire logic seq_stage_done, // sequencer stage done
  input wire logic seq_cycle_done, // sequencer cycle done
  input wire logic virt_serial_bit, // virtual bit, serial link
  input wire logic virt_fieldbus_bit, // virtual bit, fieldbus link
  input wire logic virt_ethernet_bit, // virtual bit, ethernet link
  input wire logic virt_industrial_bit, // virtual bit, industrial ethernet
  input wire logic dc_bus_ok, // dc bus above undervoltage
  input wire logic enc_index, // encoder index pulse
  input wire logic pulse_superpose, // superposition input active
  input wire logic safe_torque_off, // safe torque off fault
  input wire logic position_done, // positioning completed
  input wire logic spindle_zero_done, // spindle zeroing completed
  input wire logic spindle_div_done, // scale-division completed
  input wire logic rate_limited, // rate held by a limit
  input wire logic mode_switch_done, // speed/position switch-over done
  input wire logic logic_pgm_oc_one, // logic program bit, code 41
  input wire logic logic_pgm_oc_two, // logic program bit, code 42
  input wire logic logic_pgm_fast_out, // logic program bit, code 43
  input wire logic logic_pgm_contact_one, // logic program bit, code 44
  input wire logic logic_pgm_contact_two, // logic program bit, code 45
  input wire logic logic_pgm_contact_three, // logic program bit, code 46
  input wire logic logic_pgm_contact_four, // logic program bit, code 47
  input wire logic fast_pulse_in, // pulse train from pulse generator
  output logic oc_out, // open-collector output level
  output logic fast_pulse_output, // fast output level
  output logic contact_one_out, // first contact output level
  output logic contact_two_out // second contact output level
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int IDX_W = $clog2(INDEX_HOLD_CYC + 1); // index counter width
  localparam logic [IDX_W-1:0] IDX_LOAD = IDX_W'(INDEX_HOLD_CYC); // count loaded
  localparam logic [IDX_W-1:0] IDX_ZERO = '0; // counter idle

  ofs_code_t sel_oc_reg; // code of open-collector output
  ofs_code_t sel_fast_reg; // code of fast output
  ofs_code_t sel_c1_reg; // code of first contact
  ofs_code_t sel_c2_reg; // code of second contact
  ofs_fast_mode_e fast_mode_reg; // fast output mode
  logic pgm_enable_reg; // logic-program enable
  logic [IDX_W-1:0] idx_cnt_reg; // index hold counter
  logic idx_active; // index hold running
  logic [63:0] cond_vec; // condition per function code
  logic [6:0] pgm_bits; // logic program bits, code order
  logic [31:0] prdata_reg; // read data flop
  logic pready_reg; // ready flop
  logic pslverr_reg; // error flop
  logic [3:0] out_reg; // output levels flop
  logic setup_ph; // apb setup cycle
  logic access_done; // apb transfer completes
  logic addr_ok; // address is mapped
  logic [31:0] rd_mux; // read data of addressed register

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // pick the condition for one code; shared by all four outputs
  function automatic logic cond_pick(input ofs_code_t code, input logic [63:0] vec);
    cond_pick = vec[code];
  endfunction

  // word-aligned decode of a mapped register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction

  // ----------------------------------------------------------------
  // condition vector
  // ----------------------------------------------------------------
  assign idx_active = (idx_cnt_reg != IDX_ZERO);
  assign pgm_bits = {logic_pgm_contact_four, logic_pgm_contact_three,
                     logic_pgm_contact_two, logic_pgm_contact_one,
                     logic_pgm_fast_out, logic_pgm_oc_two, logic_pgm_oc_one};

  // unlisted and reserved codes keep their default of zero
  always_comb begin
    cond_vec = '0;
    cond_vec[`OFS_FN_RUN] = drv_running && rate_nonzero;
    cond_vec[`OFS_FN_FWD] = drv_running && rate_nonzero && !dir_reverse;
    cond_vec[`OFS_FN_REV] = drv_running && rate_nonzero && dir_reverse;
    cond_vec[`OFS_FN_JOG] = jog_active && rate_nonzero;
    cond_vec[`OFS_FN_FAULT] = drv_fault;
    cond_vec[`OFS_FN_LVL_ONE] = level_detect_one;
    cond_vec[`OFS_FN_LVL_TWO] = level_detect_two;
    cond_vec[`OFS_FN_RATE_HIT] = rate_reached;
    cond_vec[`OFS_FN_ZERO_SPD] = out_rate_zero && ref_rate_zero;
    cond_vec[`OFS_FN_UPPER] = at_upper_limit;
    cond_vec[`OFS_FN_LOWER] = at_lower_limit;
    // all four terms must hold; any protection blocks it
    cond_vec[`OFS_FN_READY] = main_pwr_ok && ctrl_pwr_ok && !protect_active && drive_ready;
    cond_vec[`OFS_FN_PREEXC] = pre_excite;
    cond_vec[`OFS_FN_OVERLOAD] = overload_alarm;
    cond_vec[`OFS_FN_UNDERLOAD] = underload_alarm;
    cond_vec[`OFS_FN_STAGE] = seq_stage_done;
    cond_vec[`OFS_FN_CYCLE] = seq_cycle_done;
    cond_vec[`OFS_FN_VIRT_SER] = virt_serial_bit;
    cond_vec[`OFS_FN_VIRT_FLD] = virt_fieldbus_bit;
    cond_vec[`OFS_FN_VIRT_ETH] = virt_ethernet_bit;
    cond_vec[`OFS_FN_VIRT_IND] = virt_industrial_bit;
    cond_vec[`OFS_FN_DC_BUS] = dc_bus_ok;
    cond_vec[`OFS_FN_INDEX] = idx_active;
    cond_vec[`OFS_FN_SUPERPOSE] = pulse_superpose;
    cond_vec[`OFS_FN_SAFE_OFF] = safe_torque_off;
    cond_vec[`OFS_FN_POS_DONE] = position_done;
    cond_vec[`OFS_FN_ZERO_DONE] = spindle_zero_done;
    cond_vec[`OFS_FN_DIV_DONE] = spindle_div_done;
    cond_vec[`OFS_FN_LIMITED] = rate_limited;
    cond_vec[`OFS_FN_SWITCHED] = mode_switch_done;
    // program bits only pass while the program is enabled
    for (int i = 0; i < `OFS_PGM_BITS; i++) begin
      cond_vec[int'(`OFS_FN_PGM_LO) + i] = pgm_bits[i] && pgm_enable_reg;
    end
  end

  // ----------------------------------------------------------------
  // index pulse stretcher
  // ----------------------------------------------------------------
  // a new index pulse restarts the hold; one shared timer serves all outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idx_cnt_reg <= IDX_ZERO;
    end else if (enc_index) begin
      idx_cnt_reg <= IDX_LOAD;
    end else if (idx_active) begin
      idx_cnt_reg <= idx_cnt_reg - IDX_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // each output reads its own code, so codes may repeat freely
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= 4'h0;
    end else begin
      out_reg[0] <= cond_pick(sel_oc_reg, cond_vec);
      // pulse mode bypasses the code; the train comes from the generator
      if (fast_mode_reg == OFS_FAST_PULSE) begin
        out_reg[1] <= fast_pulse_in;
      end else begin
        out_reg[1] <= cond_pick(sel_fast_reg, cond_vec);
      end
      out_reg[2] <= cond_pick(sel_c1_reg, cond_vec);
      out_reg[3] <= cond_pick(sel_c2_reg, cond_vec);
    end
  end

  assign oc_out = out_reg[0];
  assign fast_pulse_output = out_reg[1];
  assign contact_one_out = out_reg[2];
  assign contact_two_out = out_reg[3];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign addr_ok = addr_hit(paddr, `OFS_OFF_SEL_OC) || addr_hit(paddr, `OFS_OFF_SEL_FAST)
                || addr_hit(paddr, `OFS_OFF_SEL_C1) || addr_hit(paddr, `OFS_OFF_SEL_C2)
                || addr_hit(paddr, `OFS_OFF_CTRL) || addr_hit(paddr, `OFS_OFF_STATUS);

  // read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(paddr, `OFS_OFF_SEL_OC)) begin
      rd_mux[5:0] = sel_oc_reg;
    end else if (addr_hit(paddr, `OFS_OFF_SEL_FAST)) begin
      rd_mux[5:0] = sel_fast_reg;
    end else if (addr_hit(paddr, `OFS_OFF_SEL_C1)) begin
      rd_mux[5:0] = sel_c1_reg;
    end else if (addr_hit(paddr, `OFS_OFF_SEL_C2)) begin
      rd_mux[5:0] = sel_c2_reg;
    end else if (addr_hit(paddr, `OFS_OFF_CTRL)) begin
      rd_mux[`OFS_CTRL_MODE_BIT] = (fast_mode_reg == OFS_FAST_DIGITAL);
      rd_mux[`OFS_CTRL_PGM_BIT] = pgm_enable_reg;
    end else if (addr_hit(paddr, `OFS_OFF_STATUS)) begin
      rd_mux[4:0] = {idx_active, out_reg};
    end
  end

  // ready rises in the access cycle: one wait-free answer per transfer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && !addr_ok;
      if (setup_ph && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // register writes land at the completing edge; status is read-only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_oc_reg <= `OFS_RST_SEL_OC;
      sel_fast_reg <= `OFS_RST_SEL_FAST;
      sel_c1_reg <= `OFS_RST_SEL_C1;
      sel_c2_reg <= `OFS_RST_SEL_C2;
      fast_mode_reg <= OFS_FAST_PULSE;
      pgm_enable_reg <= 1'b0;
    end else if (access_done && pwrite) begin
      if (addr_hit(paddr, `OFS_OFF_SEL_OC)) begin
        sel_oc_reg <= pwdata[5:0];
      end
      if (addr_hit(paddr, `OFS_OFF_SEL_FAST)) begin
        sel_fast_reg <= pwdata[5:0];
      end
      if (addr_hit(paddr, `OFS_OFF_SEL_C1)) begin
        sel_c1_reg <= pwdata[5:0];
      end
      if (addr_hit(paddr, `OFS_OFF_SEL_C2)) begin
        sel_c2_reg <= pwdata[5:0];
      end
      if (addr_hit(paddr, `OFS_OFF_CTRL)) begin
        fast_mode_reg <= pwdata[`OFS_CTRL_MODE_BIT] ? OFS_FAST_DIGITAL : OFS_FAST_PULSE;
        pgm_enable_reg <= pwdata[`OFS_CTRL_PGM_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_zero_code_off: assert property (
    (sel_oc_reg == `OFS_FN_NONE) |=> !oc_out)
    else $error("code zero drove the open-collector output");

  chk_reserved_code_off: assert property (
    (sel_c1_reg == `OFS_FN_RSV_A || (sel_c1_reg >= `OFS_FN_RSV_LO && sel_c1_reg <= `OFS_FN_RSV_HI)
     || sel_c1_reg >= `OFS_FN_TOP_RSV) |=> !contact_one_out)
    else $error("reserved code drove the first contact");

  chk_run_level: assert property (
    (sel_c2_reg == `OFS_FN_RUN) |=> (contact_two_out == $past(drv_running && rate_nonzero)))
    else $error("running output wrong");

  chk_forward_level: assert property (
    (sel_oc_reg == `OFS_FN_FWD && drv_running && rate_nonzero && dir_reverse) |=> !oc_out)
    else $error("forward output on while reversing");

  chk_fault_level: assert property (
    (sel_c1_reg == `OFS_FN_FAULT) |=> (contact_one_out == $past(drv_fault)))
    else $error("fault output wrong");

  chk_zero_speed: assert property (
    (sel_c2_reg == `OFS_FN_ZERO_SPD && !(out_rate_zero && ref_rate_zero)) |=> !contact_two_out)
    else $error("zero speed output on with a rate present");

  chk_ready_block: assert property (
    (sel_c1_reg == `OFS_FN_READY && protect_active) |=> !contact_one_out)
    else $error("ready output on during protection");

  chk_index_load: assert property (
    enc_index |=> (idx_cnt_reg == IDX_LOAD))
    else $error("index hold not restarted");

  chk_index_count: assert property (
    (!enc_index && idx_active) |=> (idx_cnt_reg == $past(idx_cnt_reg) - IDX_W'(1)))
    else $error("index hold not counting down");

  chk_pgm_gate: assert property (
    (!pgm_enable_reg && sel_c2_reg >= `OFS_FN_PGM_LO && sel_c2_reg <= `OFS_FN_PGM_HI)
    |=> !contact_two_out)
    else $error("program bit passed while disabled");

  chk_same_code_same: assert property (
    (sel_oc_reg == sel_c1_reg) |=> (oc_out == contact_one_out))
    else $error("shared code gave different levels");

  chk_jog_level: assert property (
    (sel_c1_reg == `OFS_FN_JOG) |=> (contact_one_out == $past(jog_active && rate_nonzero)))
    else $error("jog output wrong");

  // the index output must track the shared hold timer, not the raw pulse
  chk_index_level: assert property (
    (sel_oc_reg == `OFS_FN_INDEX) |=> (oc_out == $past(idx_active)))
    else $error("index output does not follow the hold");

  chk_pgm_pass: assert property (
    (pgm_enable_reg && sel_c2_reg == `OFS_FN_PGM_HI)
    |=> (contact_two_out == $past(logic_pgm_contact_four)))
    else $error("program bit not passed while enabled");

  chk_pulse_mode: assert property (
    (fast_mode_reg == OFS_FAST_PULSE) |=> (fast_pulse_output == $past(fast_pulse_in)))
    else $error("fast output ignored pulse mode");

  chk_apb_answer: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");

  cov_write_ctrl: cover property (access_done && pwrite && addr_hit(paddr, `OFS_OFF_CTRL));
  cov_index_hold: cover property (enc_index ##1 idx_active [*8]);
  cov_shared_code: cover property (sel_oc_reg == sel_c2_reg && oc_out && contact_two_out);
  cov_bad_addr: cover property (pready && pslverr);

endmodule // ofs_top
